// [hdl/sac_pkg.sv]
// shared constants and state types for the converter link
package sac_pkg;

  // =========================================================
  // data widths
  localparam int RES_W     = 14;
  localparam int FRAME_W   = 16;
  localparam int CMD_W     = 16;
  localparam int BITCNT_W  = 5;
  localparam int TMR_W     = 19;

  // =========================================================
  // clock and timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_PER_NS    = 1_000_000_000 / CLK_HZ;
  localparam int CAL_DELAY_MS  = 40;
  localparam int CAL_DELAY_CYC = CAL_DELAY_MS * (CLK_HZ / 1000);
  localparam int CAL_RUN_CYC   = 64;
  localparam int CONV_CYC      = 8;
  localparam int SCLK_MAX_MHZ  = 100;
  localparam int SCLK_MIN_NS   = 1000 / SCLK_MAX_MHZ;
  localparam int SCLK_MIN_HALF = (SCLK_MIN_NS + 2 * CLK_PER_NS - 1) / (2 * CLK_PER_NS);
  localparam int SCLK_HALF     = 4;
  localparam int GAP_CYC       = 8;

  // =========================================================
  // command word layout
  localparam int        OP_MSB    = 15;
  localparam int        OP_LSB    = 12;
  localparam int        LOG_MSB   = 3;
  localparam int        LOG_LSB   = 0;
  localparam logic[3:0] OP_RECAL  = 4'ha;
  localparam logic[3:0] OP_ACCUM  = 4'hc;
  localparam int        ACC_MAX_LOG = 10;
  localparam int        ACC_W     = RES_W + ACC_MAX_LOG;
  localparam int        ACC_CNT_W = ACC_MAX_LOG + 1;
  localparam logic[3:0] ACC_LOG_RST = 4'h0;

  typedef enum logic [2:0] {S_PWRUP, S_CAL, S_STBY, S_CONV, S_DONE} sac_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_RISE, H_CONV, H_GAP, H_LOW, H_HIGH, H_END} sac_host_st_t;

endpackage

// [hdl/sac_link_if.sv]
// link wires between converter end and host end
`timescale 1ns/10ps
interface sac_link_if;
  logic convert_strobe;
  logic sclk;
  logic sdi;
  logic sdo;
  logic busy;

  modport dev (
    input  convert_strobe, sclk, sdi,
    output sdo, busy
  );

  modport host (
    output convert_strobe, sclk, sdi,
    input  sdo, busy
  );
endinterface

// [hdl/sac_dev.sv]
// converter end: conversion sequencing, calibration, accumulator, serial readout
`timescale 1ns/10ps

// Functional notes
// RL1: strobe rising edge starts a conversion
// RL2: result shown only after done and strobe low
// RL3: after presenting result, return to standby acquisition
// RL4: host clocks result out only during standby
// RL5: conversion timed by on-chip clock, not sclk
// RL6: self-calibration about 40 ms after power-up
// RL7: recalibrate command triggers full self-calibration
// RL8: after power-up calibration, enter standby
// RL9: accumulator averages up to 1024 results
// RL10: three wires plus optional busy indication; link has four wires here (convert_strobe, sclk, sdi, sdo) plus busy
// RL11: host serial clock at most 100 MHz
// RL12: 14-bit result, no pipeline latency
// RL13: result shifted out MSB first, one per clock
// RL14: command word decoded from host serial bits
module sac_dev #(
  parameter int CAL_DELAY_CYC = sac_pkg::CAL_DELAY_CYC // power-up wait in cycles
) (
  input  wire logic                      CLK_IN,      // on-chip clock
  input  wire logic                      RST_B_IN,    // sync reset, active low
  input  wire logic                      CE_IN,       // clock enable
  input  wire logic [sac_pkg::RES_W-1:0] SAMPLE_IN,   // digitised analog input
  output logic                           STANDBY_OUT, // acquisition state
  output logic [3:0]                     ACC_LOG_OUT, // accumulate exponent
  sac_link_if.dev                        LINK         // link pins
);

  // =========================================================
  // declarations
  sac_pkg::sac_dev_st_t              state_r;
  sac_pkg::sac_dev_st_t              state_nxt;
  logic [sac_pkg::TMR_W-1:0]         tmr_r;
  logic [2:0]                        strb_s;
  logic [2:0]                        sclk_s;
  logic [1:0]                        sdi_s;
  logic                              strb_rise;
  logic                              sclk_rise;
  logic                              sclk_fall;
  logic                              tmr_end;
  logic                              load_frame;
  logic                              conv_end;
  logic                              busy_r;
  logic [sac_pkg::FRAME_W-1:0]       frame_r;
  logic [sac_pkg::CMD_W-1:0]         cmd_r;
  logic [sac_pkg::BITCNT_W-1:0]      bit_cnt_r;
  logic                              cmd_stb_r;
  logic                              cmd_recal;
  logic                              cmd_accum;
  logic [3:0]                        acc_log_r;
  logic [sac_pkg::ACC_W-1:0]         acc_sum_r;
  logic [sac_pkg::ACC_W-1:0]         acc_sum_nxt;
  logic [sac_pkg::ACC_CNT_W-1:0]     acc_cnt_r;
  logic [sac_pkg::RES_W-1:0]         hold_r;
  logic [sac_pkg::RES_W-1:0]         result_r;

  // phase length in cycles as the last timer index of that phase
  function automatic logic [sac_pkg::TMR_W-1:0] last_cyc(input int n);
    last_cyc = sac_pkg::TMR_W'(n - 1);
  endfunction

  // =========================================================
  // pin synchronisers
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      strb_s <= 3'h0;
      sclk_s <= 3'h0;
      sdi_s  <= 2'h0;
    end else if (CE_IN) begin
      strb_s <= {strb_s[1:0], LINK.convert_strobe};
      sclk_s <= {sclk_s[1:0], LINK.sclk};
      sdi_s  <= {sdi_s[0], LINK.sdi};
    end
  end

  // RL1: strobe edge detect
  assign strb_rise = strb_s[1] & ~strb_s[2];
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];

  // =========================================================
  // sequencer
  assign conv_end   = (state_r == sac_pkg::S_CONV) && tmr_end;
  // RL2: load only when done and strobe low
  assign load_frame = (state_r == sac_pkg::S_DONE) && !strb_s[1];

  always_comb begin
    tmr_end = 1'b0;
    case (state_r)
      sac_pkg::S_PWRUP: tmr_end = (tmr_r == last_cyc(CAL_DELAY_CYC));
      sac_pkg::S_CAL:   tmr_end = (tmr_r == last_cyc(sac_pkg::CAL_RUN_CYC));
      sac_pkg::S_CONV:  tmr_end = (tmr_r == last_cyc(sac_pkg::CONV_CYC));
      default:          tmr_end = 1'b0;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // RL6: wait before automatic calibration
      sac_pkg::S_PWRUP: if (tmr_end) state_nxt = sac_pkg::S_CAL;
      // RL8: calibration ends in standby
      sac_pkg::S_CAL:   if (tmr_end) state_nxt = sac_pkg::S_STBY;
      sac_pkg::S_STBY: begin
        // RL1: start conversion on edge
        if (strb_rise) begin
          state_nxt = sac_pkg::S_CONV;
        // RL7: recalibrate on command
        end else if (cmd_recal) begin
          state_nxt = sac_pkg::S_CAL;
        end
      end
      // RL5: timed by own clock only
      sac_pkg::S_CONV:  if (tmr_end) state_nxt = sac_pkg::S_DONE;
      // RL3: back to acquisition
      sac_pkg::S_DONE:  if (load_frame) state_nxt = sac_pkg::S_STBY;
      default:          state_nxt = sac_pkg::S_PWRUP;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      state_r <= sac_pkg::S_PWRUP;
    end else if (CE_IN) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      tmr_r <= '0;
    end else if (CE_IN) begin
      if (state_nxt != state_r) begin
        tmr_r <= '0;
      end else if (!tmr_end) begin
        tmr_r <= tmr_r + 1'b1;
      end
    end
  end

  // RL10: busy high in power-up, calibration, conversion
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      busy_r <= 1'b1;
    end else if (CE_IN) begin
      busy_r <= (state_nxt == sac_pkg::S_PWRUP) || (state_nxt == sac_pkg::S_CAL) ||
                (state_nxt == sac_pkg::S_CONV);
    end
  end

  // =========================================================
  // sample hold and accumulator
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      hold_r <= '0;
    end else if (CE_IN && state_r == sac_pkg::S_STBY && strb_rise) begin
      hold_r <= SAMPLE_IN;
    end
  end

  assign acc_sum_nxt = acc_sum_r + sac_pkg::ACC_W'(hold_r);

  // RL9: sum 2^n results then average
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      acc_sum_r <= '0;
      acc_cnt_r <= '0;
      result_r  <= '0;
    end else if (CE_IN) begin
      if (cmd_accum) begin
        acc_sum_r <= '0;
        acc_cnt_r <= '0;
      // RL12: result from the sample just converted at exponent 0, else average of the last 2^n samples
      end else if (conv_end) begin
        if ((acc_cnt_r + 1'b1) == (sac_pkg::ACC_CNT_W'(1) << acc_log_r)) begin
          result_r  <= sac_pkg::RES_W'(acc_sum_nxt >> acc_log_r);
          acc_sum_r <= '0;
          acc_cnt_r <= '0;
        end else begin
          acc_sum_r <= acc_sum_nxt;
          acc_cnt_r <= acc_cnt_r + 1'b1;
        end
      end
    end
  end

  // =========================================================
  // serial readout and command capture
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      frame_r <= '0;
    end else if (CE_IN) begin
      if (load_frame) begin
        frame_r <= sac_pkg::FRAME_W'(result_r);
      // RL13: shift MSB first on falling sclk
      end else if (state_r == sac_pkg::S_STBY && sclk_fall) begin
        frame_r <= {frame_r[sac_pkg::FRAME_W-2:0], 1'b0};
      end
    end
  end

  // RL14: command bits taken on rising sclk
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      cmd_r     <= '0;
      bit_cnt_r <= '0;
      cmd_stb_r <= 1'b0;
    end else if (CE_IN) begin
      cmd_stb_r <= 1'b0;
      if (load_frame) begin
        bit_cnt_r <= '0;
      // RL4: link active only in standby
      end else if (state_r == sac_pkg::S_STBY && sclk_rise &&
                   bit_cnt_r != sac_pkg::BITCNT_W'(sac_pkg::CMD_W)) begin
        cmd_r     <= {cmd_r[sac_pkg::CMD_W-2:0], sdi_s[1]};
        bit_cnt_r <= bit_cnt_r + 1'b1;
        cmd_stb_r <= (bit_cnt_r == sac_pkg::BITCNT_W'(sac_pkg::CMD_W - 1));
      end
    end
  end

  assign cmd_recal = cmd_stb_r && cmd_r[sac_pkg::OP_MSB:sac_pkg::OP_LSB] == sac_pkg::OP_RECAL;
  assign cmd_accum = cmd_stb_r && cmd_r[sac_pkg::OP_MSB:sac_pkg::OP_LSB] == sac_pkg::OP_ACCUM;

  // RL9: exponent clamped to 1024 samples
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      acc_log_r <= sac_pkg::ACC_LOG_RST;
    end else if (CE_IN && cmd_accum) begin
      if (cmd_r[sac_pkg::LOG_MSB:sac_pkg::LOG_LSB] > 4'(sac_pkg::ACC_MAX_LOG)) begin
        acc_log_r <= 4'(sac_pkg::ACC_MAX_LOG);
      end else begin
        acc_log_r <= cmd_r[sac_pkg::LOG_MSB:sac_pkg::LOG_LSB];
      end
    end
  end

  // =========================================================
  // outputs
  assign LINK.sdo    = frame_r[sac_pkg::FRAME_W-1];
  assign LINK.busy   = busy_r;
  assign ACC_LOG_OUT = acc_log_r;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      STANDBY_OUT <= 1'b0;
    end else if (CE_IN) begin
      STANDBY_OUT <= (state_nxt == sac_pkg::S_STBY);
    end
  end

endmodule // sac_dev

// [hdl/sac_host.sv]
// host end: strobe sequencing, serial clock generation, result capture
`timescale 1ns/10ps
module sac_host (
  input  wire logic                      CLK_IN,           // system clock
  input  wire logic                      RST_B_IN,         // sync reset, active low
  input  wire logic                      CE_IN,            // clock enable
  input  wire logic                      START_IN,         // request conversion
  input  wire logic [sac_pkg::CMD_W-1:0] CMD_IN,           // command sent with readout
  output logic                           READY_OUT,        // request may be taken
  output logic [sac_pkg::RES_W-1:0]      RESULT_OUT,       // last result
  output logic                           RESULT_VALID_OUT, // result pulse
  sac_link_if.host                       LINK              // link pins
);

  // =========================================================
  // declarations
  sac_pkg::sac_host_st_t        state_r;
  logic [1:0]                   busy_s;
  logic [1:0]                   sdo_s;
  logic [3:0]                   cyc_r;
  logic [sac_pkg::BITCNT_W-1:0] bit_r;
  logic [sac_pkg::CMD_W-1:0]    tx_r;
  logic [sac_pkg::FRAME_W-1:0]  rx_r;
  logic                         strobe_r;
  logic                         sclk_r;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      busy_s <= 2'h3;
      sdo_s  <= 2'h0;
    end else if (CE_IN) begin
      busy_s <= {busy_s[0], LINK.busy};
      sdo_s  <= {sdo_s[0], LINK.sdo};
    end
  end

  assign READY_OUT = (state_r == sac_pkg::H_IDLE) && !busy_s[1];

  // =========================================================
  // sequencer; half period kept above the 100 MHz limit
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      state_r          <= sac_pkg::H_IDLE;
      cyc_r            <= 4'h0;
      bit_r            <= '0;
      tx_r             <= '0;
      rx_r             <= '0;
      strobe_r         <= 1'b0;
      sclk_r           <= 1'b0;
      RESULT_OUT       <= '0;
      RESULT_VALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      RESULT_VALID_OUT <= 1'b0;
      cyc_r            <= cyc_r + 1'b1;
      case (state_r)
        // RL14: command word latched with the request
        sac_pkg::H_IDLE: begin
          if (START_IN && READY_OUT) begin
            tx_r     <= CMD_IN;
            strobe_r <= 1'b1;
            state_r  <= sac_pkg::H_RISE;
          end
        end
        sac_pkg::H_RISE: if (busy_s[1]) state_r <= sac_pkg::H_CONV;
        // RL2: strobe lowered once busy falls
        sac_pkg::H_CONV: begin
          if (!busy_s[1]) begin
            strobe_r <= 1'b0;
            cyc_r    <= 4'h0;
            state_r  <= sac_pkg::H_GAP;
          end
        end
        // RL4: readout only after conversion ends
        sac_pkg::H_GAP: begin
          if (cyc_r == 4'(sac_pkg::GAP_CYC - 1)) begin
            cyc_r   <= 4'h0;
            bit_r   <= '0;
            state_r <= sac_pkg::H_LOW;
          end
        end
        // RL11: four-clock halves, far under the limit
        sac_pkg::H_LOW: begin
          if (cyc_r == 4'(sac_pkg::SCLK_HALF - 1)) begin
            cyc_r   <= 4'h0;
            sclk_r  <= 1'b1;
            state_r <= sac_pkg::H_HIGH;
          end
        end
        sac_pkg::H_HIGH: begin
          if (cyc_r == 4'(sac_pkg::SCLK_HALF - 1)) begin
            cyc_r  <= 4'h0;
            sclk_r <= 1'b0;
            rx_r   <= {rx_r[sac_pkg::FRAME_W-2:0], sdo_s[1]};
            tx_r   <= {tx_r[sac_pkg::CMD_W-2:0], 1'b0};
            bit_r  <= bit_r + 1'b1;
            if (bit_r == sac_pkg::BITCNT_W'(sac_pkg::FRAME_W - 1)) begin
              state_r <= sac_pkg::H_END;
            end else begin
              state_r <= sac_pkg::H_LOW;
            end
          end
        end
        sac_pkg::H_END: begin
          RESULT_OUT       <= rx_r[sac_pkg::RES_W-1:0];
          RESULT_VALID_OUT <= 1'b1;
          state_r          <= sac_pkg::H_IDLE;
        end
        default: state_r <= sac_pkg::H_IDLE;
      endcase
    end
  end

  assign LINK.convert_strobe = strobe_r;
  assign LINK.sclk           = sclk_r;
  assign LINK.sdi            = tx_r[sac_pkg::CMD_W-1];

endmodule // sac_host

// [tb/sac_link_assertions.sv]
// assertions on the converter link wires
`timescale 1ns/10ps
module sac_link_assertions (
  input wire logic CLK_IN,         // clock
  input wire logic RST_B_IN,       // sync reset, active low
  input wire logic convert_strobe, // start strobe
  input wire logic sclk,           // serial clock
  input wire logic sdi,            // command bit
  input wire logic sdo,            // result bit
  input wire logic busy            // converter busy
);
  logic       strb_d_r;
  logic       sclk_d_r;
  logic [4:0] rise_cnt_r;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // ==========================================================
  // sclk rises since last strobe rise
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      strb_d_r   <= 1'b0;
      sclk_d_r   <= 1'b0;
      rise_cnt_r <= 5'h00;
    end else begin
      strb_d_r <= convert_strobe;
      sclk_d_r <= sclk;
      if (convert_strobe && !strb_d_r) begin
        rise_cnt_r <= 5'h00;
      end else if (sclk && !sclk_d_r && rise_cnt_r != 5'h1f) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end

  // ==========================================================
  // link properties
  a_start_busy: assert property ($rose(convert_strobe) && !busy |-> ##[1:6] busy)
    else $error("busy did not follow strobe rise");
  a_conv_len: assert property ($rose(busy) && convert_strobe |-> busy[*8] ##1 !busy)
    else $error("conversion length wrong");
  a_strobe_hold: assert property ($rose(convert_strobe) |-> convert_strobe[*8])
    else $error("strobe dropped early");
  a_strobe_low: assert property ($fell(convert_strobe) |-> !busy)
    else $error("strobe lowered during conversion");
  a_no_sclk_conv: assert property (convert_strobe |-> !sclk)
    else $error("serial clock during conversion");
  a_sdo_stable: assert property (sclk && $past(sclk) |-> $stable(sdo))
    else $error("result bit moved while clock high");
  a_sdi_stable: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("command bit moved while clock high");
  a_frame_count: assert property (rise_cnt_r <= 5'h10)
    else $error("more than sixteen clocks in frame");
  a_frame_whole: assert property (convert_strobe && !strb_d_r |-> rise_cnt_r == 5'h00 || rise_cnt_r == 5'h10)
    else $error("partial frame before new strobe");
  a_pwrup_busy: assert property ($rose(RST_B_IN) |-> busy[*8])
    else $error("busy low right after reset");
  a_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_sclk_low: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("serial clock low phase too short");
endmodule // sac_link_assertions

// [tb/tb.sv]
// self-checking bench, host end against converter end
`timescale 1ns/10ps
module tb;
  localparam int CAL_D = 20;

  logic                      clk;
  logic                      rst_b;
  logic                      start;
  logic                      ready;
  logic                      res_vld;
  logic                      standby;
  logic                      sclk_d;
  logic [sac_pkg::RES_W-1:0] sample;
  logic [sac_pkg::RES_W-1:0] result;
  logic [15:0]               cmd;
  logic [15:0]               wire_frame;
  logic [15:0]               cmd_seen;
  logic [3:0]                acc_log;
  logic [31:0]               seed;
  int                        n_fail, compares, m_log, m_sum, m_cnt, m_res;
  int                        busy_run, last_run, n, nv, i;

  sac_link_if link ();

  sac_dev #(.CAL_DELAY_CYC(CAL_D)) u_sac_dev (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1),
    .SAMPLE_IN(sample), .STANDBY_OUT(standby), .ACC_LOG_OUT(acc_log), .LINK(link));
  sac_host u_sac_host (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1), .START_IN(start), .CMD_IN(cmd),
    .READY_OUT(ready), .RESULT_OUT(result), .RESULT_VALID_OUT(res_vld), .LINK(link));
  sac_link_assertions u_sac_link_assertions (.CLK_IN(clk), .RST_B_IN(rst_b),
    .convert_strobe(link.convert_strobe), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .busy(link.busy));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // wire monitor: frame bits, command bits, busy run length
  always @(posedge clk) begin
    if (!rst_b) begin
      sclk_d     <= 1'b0;
      wire_frame <= 16'h0000;
      cmd_seen   <= 16'h0000;
      busy_run   <= 0;
      last_run   <= 0;
    end else begin
      sclk_d <= link.sclk;
      if (sclk_d && !link.sclk) wire_frame <= {wire_frame[14:0], link.sdo};
      if (!sclk_d && link.sclk) cmd_seen <= {cmd_seen[14:0], link.sdi};
      if (link.busy === 1'b1) busy_run <= busy_run + 1;
      else if (busy_run != 0) begin
        last_run <= busy_run;
        busy_run <= 0;
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one conversion and readout, checked against the model
  task automatic xfer(input logic [13:0] smp, input logic [15:0] cw);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    check(ready, 1);
    sample = smp;
    cmd = cw;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (res_vld !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    check(res_vld, 1);
    repeat (4) @(negedge clk);
    if (m_log == 0) m_res = smp;
    else begin
      m_sum += smp;
      m_cnt++;
      if (m_cnt == (1 << m_log)) begin
        m_res = m_sum >> m_log;
        m_sum = 0;
        m_cnt = 0;
      end
    end
    check(result, m_res);
    check(wire_frame, m_res);
    check(cmd_seen, cw);
    if (cw[15:12] == 4'hc) begin
      m_log = (cw[3:0] > 10) ? 10 : cw[3:0];
      m_sum = 0;
      m_cnt = 0;
      check(acc_log, m_log);
    end
    if (cw[15:12] != 4'ha) check(standby, 1);
  endtask

  initial begin
    #1_000_000;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    sample = 14'h0000;
    cmd = 16'h0000;
    seed = 32'h59a5;
    n_fail = 0;
    compares = 0;
    m_log = 0;
    m_sum = 0;
    m_cnt = 0;
    m_res = 0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    n = 0;
    while (link.busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(link.busy, 0);
    repeat (3) @(negedge clk);
    check(last_run >= CAL_D + 64 && last_run <= CAL_D + 66, 1);
    check(standby, 1);
    check(acc_log, 0);
    $display("test power-up done");
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      xfer((i == 0) ? 14'h3fff : (i == 1) ? 14'h0000 : seed[13:0], {i[3:0], seed[27:16]});
    end
    $display("test plain transfers done");
    seed = xs(seed);
    xfer(seed[13:0], 16'hc002);
    for (i = 0; i < 5; i++) begin
      seed = xs(seed);
      xfer(seed[13:0], 16'h0000);
    end
    seed = xs(seed);
    xfer(seed[13:0], 16'hc00f);
    seed = xs(seed);
    xfer(seed[13:0], 16'hc000);
    $display("test accumulator done");
    seed = xs(seed);
    xfer(seed[13:0], 16'ha000);
    check(link.busy, 1);
    check(standby, 0);
    check(ready, 0);
    start = 1'b1;
    n = 0;
    nv = 0;
    while (link.busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
      if (res_vld === 1'b1) nv++;
    end
    check(link.busy, 0);
    start = 1'b0;
    repeat (2) @(negedge clk);
    check(last_run, sac_pkg::CAL_RUN_CYC);
    check(nv, 0);
    seed = xs(seed);
    xfer(seed[13:0], 16'h0000);
    $display("test recalibration done");
    end_of_test();
  end
endmodule // tb
